// *** flash_pins_pkg.sv ***
package flash_pins_pkg;

  // ****************************************************************
  // Widths and counts
  // ****************************************************************
  localparam int unsigned DQ_WIDTH        = 8;
  localparam int unsigned TIMEOUT_WIDTH   = 16;
  localparam logic [15:0] TIMEOUT_DEFAULT = 16'h0040;
  localparam int unsigned SYNC_STAGES     = 2;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic        PIN_RELEASED    = 1'b1;
  localparam logic [7:0]  DQ_RESET        = 8'h00;

  // ****************************************************************
  // Link mode and states
  // ****************************************************************
  typedef enum logic [1:0]
  {
    BOOT_POR     = 2'b00,
    BOOT_HOLD    = 2'b01,
    BOOT_STANDBY = 2'b10,
    BOOT_ACTIVE  = 2'b11
  } boot_state_e;

  // Data from the core that feeds the pins
  typedef struct packed
  {
    logic       octal_mode;
    logic       read_phase;
    logic [7:0] read_data;
  } core_drive_s;

  // Pin output group
  typedef struct packed
  {
    logic [7:0] dq_out;
    logic [7:0] dq_oe;
    logic       strobe_out;
    logic       strobe_oe;
  } pin_drive_s;

endpackage : flash_pins_pkg

// *** pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned      WIDTH     = 1,
  // Reset value per bit should match each pin's idle level
  parameter logic [WIDTH-1:0] RESET_VAL = '1
)
(
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  // Asynchronous level in, synchronised level out
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // ****************************************************************
  // Two flops; only the second one is read
  // ****************************************************************
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule : pin_sync

// *** flash_host_pin_control.sv ***
`timescale 1ns/1ps
// Contract
// - Strobe toggles only in reads with select low; data edge-aligned to it
// - Single-bit mode: line 0 is input only, line 1 is output only
// - Octal mode: all eight data lines are bidirectional
// - Reset input low reinitialises; afterwards the array read state returns
// - Reset input low floats strobe and all eight data lines
// - Unconnected reset input reads as high through a weak pull-up
// - Event output pulled low on an internal event, else released
// - Reset output held low during internal power-on reset
// - Reset output stays low for a configured timeout after power-on
// - Device enters standby as soon as reset output releases
// - While reset output low: ignore select, no transactions, drive nothing
// - Host clock may stop between transfers; device still works
// - Select falling starts, rising ends; select high floats and idles
// - Events include busy-to-ready and error-correction detection on read
module flash_host_pin_control #(
  parameter int unsigned TIMEOUT_W = flash_pins_pkg::TIMEOUT_WIDTH
)
(
  // Clock and reset
  input  wire logic                          clock_i,
  input  wire logic                          rst_i,
  // Host pins, asynchronous to clock_i
  input  wire logic                          select_n_i,
  input  wire logic                          host_clock_i,
  input  wire logic                          hw_reset_n_i,
  input  wire logic [7:0]                    dq_i,
  // Core side, same clock
  input  wire logic                          por_busy_i,
  input  wire logic [TIMEOUT_W-1:0]          timeout_cfg_i,
  input  wire flash_pins_pkg::core_drive_s   core_i,
  input  wire logic                          op_done_i,
  input  wire logic                          ecc_event_i,
  input  wire logic                          event_ack_i,
  input  wire logic                          embedded_busy_i,
  // Data and strobe pins
  output flash_pins_pkg::pin_drive_s         pins_o,
  // Open-drain outputs, enable high pulls low
  output logic                               event_out_n_o,
  output logic                               event_oe_o,
  output logic                               boot_hold_out_n_o,
  output logic                               boot_hold_oe_o,
  // Status to core
  output logic                               standby_o,
  output logic                               reinit_o,
  output logic                               txn_start_o,
  output logic                               txn_end_o,
  output logic                               host_clock_rise_o,
  output logic                               host_clock_fall_o,
  output logic [7:0]                         dq_sampled_o
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [10:0] pins_raw;
  logic [10:0] pins_sync;

  // A floating reset pin arrives as 1 via the pull-up; sync resets high
  // Host clock resets low like its idle level, so no false edge follows
  assign pins_raw = {select_n_i, host_clock_i, hw_reset_n_i, dq_i};

  pin_sync #(
    .WIDTH     (11),
    .RESET_VAL ({1'b1, 1'b0, 1'b1, 8'h00})
  ) u_sync (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .async_i     (pins_raw),
    .sync_o      (pins_sync)
  );

  logic       sel_n_s;
  logic       hclk_s;
  logic       hrst_n_s;
  logic [7:0] dq_s;

  assign sel_n_s  = pins_sync[10];
  assign hclk_s   = pins_sync[9];
  assign hrst_n_s = pins_sync[8];
  assign dq_s     = pins_sync[7:0];

  // ****************************************************************
  // Edge detection on synchronised levels
  // ****************************************************************
  logic sel_n_q;
  logic hclk_q;

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sel_n_q <= 1'b1;
      hclk_q  <= 1'b0;
    end
    else
    begin
      sel_n_q <= sel_n_s;
      hclk_q  <= hclk_s;
    end
  end

  // ****************************************************************
  // Boot hold sequencing
  // ****************************************************************
  flash_pins_pkg::boot_state_e state_q;
  logic [TIMEOUT_W-1:0]        count_q;
  logic                        blocked;

  assign blocked = (state_q == flash_pins_pkg::BOOT_POR) ||
                   (state_q == flash_pins_pkg::BOOT_HOLD);

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= flash_pins_pkg::BOOT_POR;
      count_q <= '0;
    end
    else if (!hrst_n_s)
    begin
      // Hardware reset reruns the same sequence as power-on
      state_q <= flash_pins_pkg::BOOT_POR;
      count_q <= '0;
    end
    else
    begin
      case (state_q)
        flash_pins_pkg::BOOT_POR:
        begin
          if (!por_busy_i)
          begin
            state_q <= flash_pins_pkg::BOOT_HOLD;
            count_q <= timeout_cfg_i;
          end
        end
        flash_pins_pkg::BOOT_HOLD:
        begin
          if (count_q == '0)
            state_q <= flash_pins_pkg::BOOT_STANDBY;
          else
            count_q <= count_q - 1'b1;
        end
        flash_pins_pkg::BOOT_STANDBY:
        begin
          // Blocked states skip select entirely
          if (!sel_n_s && sel_n_q)
            state_q <= flash_pins_pkg::BOOT_ACTIVE;
        end
        flash_pins_pkg::BOOT_ACTIVE:
        begin
          if (sel_n_s)
            state_q <= flash_pins_pkg::BOOT_STANDBY;
        end
        default:
        begin
          state_q <= flash_pins_pkg::BOOT_POR;
        end
      endcase
    end
  end

  // ****************************************************************
  // Reset and standby outputs
  // ****************************************************************
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      boot_hold_oe_o    <= 1'b1;
      boot_hold_out_n_o <= 1'b0;
      standby_o         <= 1'b0;
      reinit_o          <= 1'b1;
    end
    else
    begin
      boot_hold_oe_o    <= blocked;
      boot_hold_out_n_o <= 1'b0;
      // Embedded work keeps the core awake even with select high
      standby_o         <= (state_q == flash_pins_pkg::BOOT_STANDBY) &&
                           !embedded_busy_i;
      reinit_o          <= blocked || !hrst_n_s;
    end
  end

  // ****************************************************************
  // Transaction framing and host clock edges
  // ****************************************************************
  logic active;

  assign active = (state_q == flash_pins_pkg::BOOT_ACTIVE) && !sel_n_s;

  // Edges are found only from samples, so a stopped clock simply
  // produces no edges and nothing else waits on it
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      txn_start_o       <= 1'b0;
      txn_end_o         <= 1'b0;
      host_clock_rise_o <= 1'b0;
      host_clock_fall_o <= 1'b0;
      dq_sampled_o      <= flash_pins_pkg::DQ_RESET;
    end
    else
    begin
      txn_start_o       <= !blocked && hrst_n_s &&
                           !sel_n_s && sel_n_q;
      txn_end_o         <= (state_q == flash_pins_pkg::BOOT_ACTIVE) &&
                           sel_n_s;
      host_clock_rise_o <= active && hclk_s && !hclk_q;
      host_clock_fall_o <= active && !hclk_s && hclk_q;
      if (active && (hclk_s != hclk_q))
      begin
        // Single-bit mode listens on line 0 only
        if (core_i.octal_mode)
          dq_sampled_o <= dq_s;
        else
          dq_sampled_o <= {7'h00, dq_s[0]};
      end
    end
  end

  // ****************************************************************
  // Data and strobe drivers
  // ****************************************************************
  logic reading;

  assign reading = active && hrst_n_s && core_i.read_phase;

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pins_o <= '0;
    end
    else if (!reading)
    begin
      // Reset pin low, blocked, or select high: everything floats
      pins_o <= '0;
    end
    else
    begin
      pins_o.strobe_oe <= core_i.octal_mode;
      if (core_i.octal_mode)
      begin
        // Data and strobe change on the same edge: edge aligned
        if (hclk_s != hclk_q)
        begin
          pins_o.dq_out     <= core_i.read_data;
          pins_o.strobe_out <= hclk_s;
        end
        pins_o.dq_oe <= 8'hFF;
      end
      else
      begin
        // Output only on line 1, updated at host clock fall
        if (!hclk_s && hclk_q)
          pins_o.dq_out <= {6'h00, core_i.read_data[0], 1'b0};
        pins_o.dq_oe      <= 8'h02;
        pins_o.strobe_out <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Event output
  // ****************************************************************
  // Sticky until the core acknowledges; a new event wins over the ack
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      event_oe_o    <= 1'b0;
      event_out_n_o <= 1'b0;
    end
    else
    begin
      event_out_n_o <= 1'b0;
      // Only the reset output may drive while held, so events then drop
      if (blocked)
        event_oe_o <= 1'b0;
      else if (op_done_i || ecc_event_i)
        event_oe_o <= 1'b1;
      else if (event_ack_i)
        event_oe_o <= 1'b0;
    end
  end

endmodule : flash_host_pin_control

// *** pin_control_checker.sv ***
`timescale 1ns/1ps
module pin_control_checker #(
  parameter int unsigned TIMEOUT_W = 16
)
(
  // Clock and reset
  input wire logic                        clock_i,
  input wire logic                        rst_i,
  // Watched inputs
  input wire logic                        select_n_i,
  input wire logic                        hw_reset_n_i,
  input wire logic                        por_busy_i,
  input wire logic [TIMEOUT_W-1:0]        timeout_cfg_i,
  input wire flash_pins_pkg::core_drive_s core_i,
  input wire logic                        op_done_i,
  input wire logic                        ecc_event_i,
  // Watched outputs
  input wire flash_pins_pkg::pin_drive_s  pins_o,
  input wire logic                        event_out_n_o,
  input wire logic                        event_oe_o,
  input wire logic                        boot_hold_oe_o,
  input wire logic                        standby_o,
  input wire logic                        txn_start_o
);
  logic [TIMEOUT_W:0] held_q;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence floated;
    pins_o.dq_oe == 8'h00 && !pins_o.strobe_oe;
  endsequence
  sequence spi_mode;
    (!core_i.octal_mode) [*2];
  endsequence
  // No wrap guard: bench timeouts are far below the counter range
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      held_q <= '0;
    else if (por_busy_i || !boot_hold_oe_o)
      held_q <= '0;
    else
      held_q <= held_q + 1'b1;
  end
  a_por_holds: assert property (por_busy_i |=> boot_hold_oe_o)
    else $error("reset output released during power-on");
  a_hold_count: assert property ($fell(boot_hold_oe_o) |->
    held_q >= {1'b0, timeout_cfg_i}) else $error("hold timeout too short");
  a_release_idle: assert property ($fell(boot_hold_oe_o) |-> standby_o)
    else $error("no standby at release");
  a_hold_floats: assert property (boot_hold_oe_o |-> floated)
    else $error("pins driven during hold");
  a_start_legal: assert property (txn_start_o |->
    !boot_hold_oe_o && $past(select_n_i, 2) == 1'b0)
    else $error("start without select");
  a_hw_floats: assert property (!hw_reset_n_i [*4] |-> floated)
    else $error("pins driven in reset");
  a_idle_floats: assert property (select_n_i [*6] |-> floated)
    else $error("pins driven while deselected");
  a_spi_lines: assert property (spi_mode |-> !pins_o.dq_oe[0] &&
    pins_o.dq_oe[7:2] == 6'h00 && !pins_o.strobe_oe)
    else $error("wrong lines driven in single-bit mode");
  a_event_set: assert property ((op_done_i || ecc_event_i) |=>
    (boot_hold_oe_o || (event_oe_o && !event_out_n_o)))
    else $error("event not shown");
  a_event_quiet: assert property (boot_hold_oe_o |-> !event_oe_o)
    else $error("event output driven during hold");
endmodule : pin_control_checker
bind flash_host_pin_control pin_control_checker #(.TIMEOUT_W(TIMEOUT_W)) chk
  (.clock_i, .rst_i, .select_n_i, .hw_reset_n_i, .por_busy_i, .timeout_cfg_i,
   .core_i, .op_done_i, .ecc_event_i, .pins_o, .event_out_n_o, .event_oe_o,
   .boot_hold_oe_o, .standby_o, .txn_start_o);

// *** host_model.sv ***
`timescale 1ns/1ps
module host_model
(
  // Frame request
  input  wire logic       start_i,
  input  wire logic [7:0] cmd_i,
  // Host pins
  output logic            select_n_o,
  output logic            host_clock_o,
  output logic [7:0]      dq_o,
  output logic            busy_o
);
  initial
  begin
    select_n_o   = 1'b1;
    host_clock_o = 1'b0;
    dq_o         = 8'h5A;
    busy_o       = 1'b0;
  end
  // Idle lines keep changing so stale data cannot match
  always #4 if (!busy_o) dq_o = ~dq_o;
  always @(posedge start_i)
  begin
    busy_o = 1'b1;
    select_n_o = 1'b0;
    dq_o = cmd_i;
    #100;
    repeat (8) #62.5 host_clock_o = ~host_clock_o;
    #100;
    select_n_o = 1'b1;
    busy_o = 1'b0;
  end
endmodule : host_model

// *** flash_host_pin_control_bench.sv ***
`timescale 1ns/1ps
module flash_host_pin_control_bench;
  logic clock_i, rst_i, por_busy_i, op_done_i, ecc_event_i, event_ack_i;
  logic embedded_busy_i, hw_low, go, busy, s_prev, select_n_i, host_clock_i;
  logic event_out_n_o, event_oe_o, boot_hold_out_n_o, boot_hold_oe_o;
  logic standby_o, reinit_o, txn_start_o, txn_end_o;
  logic host_clock_rise_o, host_clock_fall_o;
  logic [7:0] dq_i, dq_sampled_o, oe_seen, cmd, dq_seen;
  logic [15:0] timeout_cfg_i;
  flash_pins_pkg::core_drive_s core_i;
  flash_pins_pkg::pin_drive_s pins_o;
  wire hw_reset_n_i;
  int err_total, checks, cyc, starts, ends, rises, falls, strobes, c0;
  pullup (hw_reset_n_i);
  assign hw_reset_n_i = hw_low ? 1'b0 : 1'bz;
  host_model host (.start_i(go), .cmd_i(cmd), .select_n_o(select_n_i),
    .host_clock_o(host_clock_i), .dq_o(dq_i), .busy_o(busy));
  flash_host_pin_control #(.TIMEOUT_W(16)) uut (.clock_i, .rst_i, .select_n_i,
    .host_clock_i, .hw_reset_n_i, .dq_i, .por_busy_i, .timeout_cfg_i, .core_i,
    .op_done_i, .ecc_event_i, .event_ack_i, .embedded_busy_i, .pins_o,
    .event_out_n_o, .event_oe_o, .boot_hold_out_n_o, .boot_hold_oe_o,
    .standby_o, .reinit_o, .txn_start_o, .txn_end_o, .host_clock_rise_o,
    .host_clock_fall_o, .dq_sampled_o);
  initial
  begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  always @(posedge clock_i)
  begin
    cyc++;
    starts += txn_start_o;
    ends += txn_end_o;
    rises += host_clock_rise_o;
    falls += host_clock_fall_o;
    oe_seen |= pins_o.dq_oe;
    dq_seen |= pins_o.dq_out & pins_o.dq_oe;
    strobes += pins_o.strobe_oe && pins_o.strobe_out !== s_prev;
    s_prev = pins_o.strobe_out;
    if (cyc == 20000)
    begin
      err_total++;
      report_and_stop();
    end
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    if (seen !== exp)
      err_total++;
  endtask : check
  task frame(input logic [7:0] c);
    @(negedge clock_i) cmd = c;
    go = 1'b1;
    @(negedge clock_i) go = 1'b0;
    wait (busy == 1'b0);
    repeat (8) @(negedge clock_i);
  endtask : frame
  task test_boot;
    check(boot_hold_oe_o, 1'b1);
    check(boot_hold_out_n_o, 1'b0);
    @(negedge clock_i) por_busy_i = 1'b0;
    c0 = cyc;
    frame(8'h9F); // Refused: still inside the hold window
    check(starts, 0);
    wait (boot_hold_oe_o == 1'b0);
    check(cyc - c0 >= 16'h0101 && cyc - c0 <= 16'h0106, 1'b1);
    @(negedge clock_i) check(standby_o, 1'b1);
    $display("test boot done");
  endtask : test_boot
  task test_read(input logic oct, input logic [7:0] c);
    int s0;
    core_i = '{oct, 1'b1, 8'hA5};
    s0 = strobes;
    oe_seen = 8'h00;
    dq_seen = 8'h00;
    starts = 0;
    ends = 0;
    rises = 0;
    falls = 0;
    frame(c);
    check(starts, 1);
    check(ends, 1);
    check(rises, 4);
    check(falls, 4);
    check(oe_seen, oct ? 8'hFF : 8'h02);
    check(strobes > s0, oct);
    check(dq_seen, oct ? 8'hA5 : 8'h02);
    if (oct)
      check(dq_sampled_o, c);
    else
      check(dq_sampled_o, {7'h00, c[0]});
    check(pins_o.dq_oe, 8'h00);
    $display("test read done");
  endtask : test_read
  task test_hw_reset;
    fork
      frame(8'hEB);
    join_none
    #300;
    @(negedge clock_i) hw_low = 1'b1;
    repeat (6) @(negedge clock_i);
    check(pins_o.dq_oe, 8'h00);
    check(pins_o.strobe_oe, 1'b0);
    check(reinit_o, 1'b1);
    hw_low = 1'b0;
    wait (busy == 1'b0);
    wait (boot_hold_oe_o == 1'b0);
    @(negedge clock_i) check(standby_o, 1'b1);
    $display("test hw reset done");
  endtask : test_hw_reset
  task pulse(input logic d, input logic e, input logic a, input logic exp);
    @(negedge clock_i) {op_done_i, ecc_event_i, event_ack_i} = {d, e, a};
    @(negedge clock_i) {op_done_i, ecc_event_i, event_ack_i} = 3'h0;
    @(negedge clock_i) check(event_oe_o, exp);
    check(event_out_n_o, 1'b0);
  endtask : pulse
  task test_events;
    pulse(1'b1, 1'b0, 1'b0, 1'b1);
    pulse(1'b0, 1'b0, 1'b1, 1'b0);
    pulse(1'b0, 1'b1, 1'b1, 1'b1);
    pulse(1'b0, 1'b0, 1'b1, 1'b0);
    embedded_busy_i = 1'b1;
    repeat (4) @(negedge clock_i);
    check(standby_o, 1'b0);
    embedded_busy_i = 1'b0;
    repeat (4) @(negedge clock_i);
    check(standby_o, 1'b1);
    $display("test events done");
  endtask : test_events
  task report_and_stop;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  initial
  begin
    {rst_i, por_busy_i, hw_low, go, s_prev} = 5'h18;
    {op_done_i, ecc_event_i, event_ack_i, embedded_busy_i} = 4'h0;
    timeout_cfg_i = 16'h0100;
    core_i = '{1'b1, 1'b0, 8'h00};
    cmd = 8'h00;
    repeat (16) @(negedge clock_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clock_i);
    test_boot();
    test_read(1'b1, 8'hC3);
    test_read(1'b0, 8'h3C);
    test_hw_reset();
    test_events();
    report_and_stop();
  end
endmodule : flash_host_pin_control_bench
